// >>> verilog/csb_defines.svh
// Constants for the status bus command controller: codes, offsets, timing.
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH
`define CSB_ST_IRQ_ACK_STROBE     3'h0
`define CSB_ST_IORD     3'h1
`define CSB_ST_IOWR     3'h2
`define CSB_ST_HALT     3'h3
`define CSB_ST_FETCH    3'h4
`define CSB_ST_MEMRD    3'h5
`define CSB_ST_MEMWR    3'h6
`define CSB_ST_PASSIVE  3'h7
`define CSB_CLK_NS      100
`define CSB_GRANT_NS    105
`define CSB_GRANT_CYC   ((`CSB_GRANT_NS + `CSB_CLK_NS - 1) / `CSB_CLK_NS)
`define CSB_OFS_CTRL    12'h000
`define CSB_OFS_STATUS  12'h004
`define CSB_OFS_CYCLES  12'h008
`define CSB_CTRL_INHIBIT 0
`define CSB_CTRL_RST    32'h0000_0000
`endif

// >>> verilog/csb_pkg.sv
// Types shared by the status bus command controller files.
package csb_pkg;
  typedef enum logic [1:0] {
    CSB_IDLE,
    CSB_ADDR,
    CSB_EARLY,
    CSB_FULL
  } csb_state_t;

  // Command strobes, active high inside the block.
  typedef struct packed {
    logic irq_ack_strobe;
    logic io_rd;
    logic io_wr;
    logic io_wr_early;
    logic mem_rd;
    logic mem_wr;
    logic mem_wr_early;
  } csb_cmd_t;

  typedef struct packed {
    logic [15:0] cycles;
    logic        grant_ok;
    logic        strap;
    logic [1:0]  state;
    logic [2:0]  status;
  } csb_stat_t;
endpackage

// >>> verilog/csb_sync.sv
// Two-flop synchroniser for a group of pin inputs.
module csb_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        meta_q[i] <= RST_VAL[i];
        q[i]      <= RST_VAL[i];
      end
      else
      begin
        meta_q[i] <= d[i];
        q[i]      <= meta_q[i];
      end
    end
  end
endmodule

// >>> verilog/csb_apb_regs.sv
// APB slave holding the control word and showing controller status.
`include "csb_defines.svh"
module csb_apb_regs (
  // APB
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Block side
  input  wire csb_pkg::csb_stat_t stat,
  output logic                   inhibit
);
  logic [31:0] ctrl_q;
  wire         hit_ctrl = (paddr == `CSB_OFS_CTRL);
  wire         hit_stat = (paddr == `CSB_OFS_STATUS);
  wire         hit_cyc  = (paddr == `CSB_OFS_CYCLES);
  wire         mapped   = hit_ctrl | hit_stat | hit_cyc;
  wire         setup    = psel & ~penable;
  wire         wr_take  = psel & penable & pready & pwrite & hit_ctrl;
  wire [31:0]  rd_mux   = hit_ctrl ? ctrl_q :
                          hit_stat ? {25'h0, stat.grant_ok, stat.strap,
                                      stat.state, stat.status} :
                          hit_cyc  ? {16'h0, stat.cycles} : 32'h0;

  // One wait-free access: ready rises in the access phase after setup.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q  <= `CSB_CTRL_RST;
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? rd_mux : prdata;
      if (wr_take)
        ctrl_q <= {31'h0, pwdata[`CSB_CTRL_INHIBIT]};
    end
  end

  assign inhibit = ctrl_q[`CSB_CTRL_INHIBIT];
endmodule

// >>> verilog/csb_bus_controller.sv
// Status-line decoder producing command and transceiver strobes.
// Functional notes
// - Status 000 acknowledges interrupt, 001 reads I/O, 010 writes I/O, 011 halts.
// - Status 100 and 101 read memory, 110 writes memory, 111 is passive.
// - With strap high, I/O and acknowledge strobes ignore the bus grant.
// - With strap high, I/O strobes start at once; peripheral enable steers transceiver.
// - With strap high, memory strobes wait for the bus grant.
// - With strap low, all strobes wait 105 ns after grant falls.
// - Grant rising high tri-states the command drivers immediately; here they turn off three edges later, and I/O ones only with strap low.
// - Early write strobes come before the normal write strobes.
// - Interrupt acknowledge is timed like an I/O read.
// - Transceiver enable connects buses; direction output picks transfer direction.
// - Direction is high for writes and low for reads.
// - With strap high the shared pin is the peripheral data enable.
// - With strap low the shared pin is cascade enable during acknowledges.
// - Cascade enable rises just before the acknowledge cycle, with address strobe.
// - Address strobe pulses once per machine cycle and latches the status.
// - Address strobe is active high; latches close on its falling edge.
// - Address and cascade strobes lead from the later of clock or status.
// - Low qualifier drives every command inactive, never tri-stated.
// - Low qualifier also forces both data enables inactive.
//
// Design decisions made here: the APB register port and the register addresses.
`include "csb_defines.svh"
module csb_bus_controller #(
  parameter int GRANT_CYC = `CSB_GRANT_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Processor status
  input  wire logic        status_line_0,
  input  wire logic        status_line_1,
  input  wire logic        status_line_2,
  // Arbitration and qualifiers
  input  wire logic        bus_grant_n,
  input  wire logic        command_qualifier,
  input  wire logic        bus_mode_strap,
  // Command strobes, active low
  output logic             irq_ack_strobe_n,
  output logic             io_read_strobe_n,
  output logic             io_write_strobe_n,
  output logic             early_io_write_strobe_n,
  output logic             mem_read_strobe_n,
  output logic             mem_write_strobe_n,
  output logic             early_mem_write_strobe_n,
  // Command driver enables
  output logic             io_cmd_oe,
  output logic             mem_cmd_oe,
  // Control outputs
  output logic             addr_latch_strobe,
  output logic             data_xcvr_enable,
  output logic             xfer_direction,
  output logic             cascade_or_periph_enable
);
  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [5:0] pins_s;
  wire  [2:0] stat_s   = pins_s[2:0];
  wire        grant_ns = pins_s[3];
  wire        qual_s   = pins_s[4];
  wire        strap_s  = pins_s[5];

  csb_sync #(
    .W       (6),
    .RST_VAL (6'h0f)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({bus_mode_strap, command_qualifier, bus_grant_n,
               status_line_2, status_line_1, status_line_0}),
    .q       (pins_s)
  );

  // ****************************************************************
  // Register bus
  // ****************************************************************
  csb_pkg::csb_stat_t stat;
  logic               inhibit;

  csb_apb_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .stat    (stat),
    .inhibit (inhibit)
  );

  // ****************************************************************
  // Machine cycle sequencing
  // ****************************************************************
  csb_pkg::csb_state_t st_q;
  csb_pkg::csb_state_t st_d;
  logic [2:0]          stat_q;
  logic [15:0]         cycles_q;

  wire passive = (stat_s == `CSB_ST_PASSIVE);
  wire start   = (st_q == csb_pkg::CSB_IDLE) & ~passive;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      csb_pkg::CSB_IDLE:  st_d = passive ? csb_pkg::CSB_IDLE : csb_pkg::CSB_ADDR;
      csb_pkg::CSB_ADDR:  st_d = passive ? csb_pkg::CSB_IDLE : csb_pkg::CSB_EARLY;
      csb_pkg::CSB_EARLY: st_d = passive ? csb_pkg::CSB_IDLE : csb_pkg::CSB_FULL;
      csb_pkg::CSB_FULL:  st_d = passive ? csb_pkg::CSB_IDLE : csb_pkg::CSB_FULL;
      default:            st_d = csb_pkg::CSB_IDLE;
    endcase
  end

  // Status is captured with the address strobe, as the halt latch does.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q     <= csb_pkg::CSB_IDLE;
      stat_q   <= `CSB_ST_PASSIVE;
      cycles_q <= 16'h0;
    end
    else
    begin
      st_q     <= st_d;
      stat_q   <= start ? stat_s : stat_q;
      cycles_q <= start ? cycles_q + 16'h1 : cycles_q;
    end
  end

  // ****************************************************************
  // Bus grant timing
  // ****************************************************************
  // The count restarts whenever the grant is lost, so a short grant
  // glitch can never release commands early.
  logic [7:0] grant_cnt_q;
  // A grant lost mid-cycle withdraws commands at once, not an edge later.
  wire        grant_ok = ~grant_ns & (grant_cnt_q == 8'(GRANT_CYC));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      grant_cnt_q <= 8'h0;
    else if (grant_ns)
      grant_cnt_q <= 8'h0;
    else if (!grant_ok)
      grant_cnt_q <= grant_cnt_q + 8'h1;
  end

  // ****************************************************************
  // Decode and qualification
  // ****************************************************************
  wire is_irq_ack_strobe  = (stat_q == `CSB_ST_IRQ_ACK_STROBE);
  wire is_iord  = (stat_q == `CSB_ST_IORD);
  wire is_iowr  = (stat_q == `CSB_ST_IOWR);
  wire is_memrd = (stat_q == `CSB_ST_FETCH) |
                  (stat_q == `CSB_ST_MEMRD);
  wire is_memwr = (stat_q == `CSB_ST_MEMWR);
  wire is_io    = is_irq_ack_strobe | is_iord | is_iowr;
  wire is_mem   = is_memrd | is_memwr;
  wire qual     = qual_s & ~inhibit;
  wire io_en    = strap_s | grant_ok;
  wire mem_en   = grant_ok;
  wire ph_rd    = ~passive & ((st_q == csb_pkg::CSB_EARLY) |
                              (st_q == csb_pkg::CSB_FULL));
  wire ph_wr    = ~passive & (st_q == csb_pkg::CSB_FULL);
  wire io_go    = ph_rd & qual & io_en;
  wire mem_go   = ph_rd & qual & mem_en;

  csb_pkg::csb_cmd_t cmd_d;
  assign cmd_d.irq_ack_strobe         = io_go & is_irq_ack_strobe;
  assign cmd_d.io_rd        = io_go & is_iord;
  assign cmd_d.io_wr_early  = io_go & is_iowr;
  assign cmd_d.io_wr        = io_go & is_iowr & ph_wr;
  assign cmd_d.mem_rd       = mem_go & is_memrd;
  assign cmd_d.mem_wr_early = mem_go & is_memwr;
  assign cmd_d.mem_wr       = mem_go & is_memwr & ph_wr;

  // Direction follows the status at once so the transceiver turns
  // round before its enable rises.
  wire [2:0] dir_code = start ? stat_s : stat_q;
  wire dir_d  = ~passive & ((dir_code == `CSB_ST_IOWR) |
                            (dir_code == `CSB_ST_MEMWR));
  wire peripheral_data_enable_n_d = strap_s & io_go & is_io;
  wire den_d  = ph_rd & qual & (strap_s ? (is_mem & mem_en) :
                                (is_mem | is_io) & grant_ok);
  wire mce_d  = ~strap_s & start & (stat_s == `CSB_ST_IRQ_ACK_STROBE);
  wire cpe_d  = strap_s ? ~peripheral_data_enable_n_d : mce_d;

  // ****************************************************************
  // Output registers
  // ****************************************************************
  csb_pkg::csb_cmd_t cmd_n_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_n_q                  <= '1;
      io_cmd_oe                <= 1'b0;
      mem_cmd_oe               <= 1'b0;
      addr_latch_strobe        <= 1'b0;
      data_xcvr_enable         <= 1'b0;
      xfer_direction           <= 1'b0;
      cascade_or_periph_enable <= 1'b0;
    end
    else
    begin
      cmd_n_q                  <= ~cmd_d;
      io_cmd_oe                <= strap_s | ~grant_ns;
      mem_cmd_oe               <= ~grant_ns;
      addr_latch_strobe        <= start;
      data_xcvr_enable         <= den_d;
      xfer_direction           <= dir_d;
      cascade_or_periph_enable <= cpe_d;
    end
  end

  assign irq_ack_strobe_n         = cmd_n_q.irq_ack_strobe;
  assign io_read_strobe_n         = cmd_n_q.io_rd;
  assign io_write_strobe_n        = cmd_n_q.io_wr;
  assign early_io_write_strobe_n  = cmd_n_q.io_wr_early;
  assign mem_read_strobe_n        = cmd_n_q.mem_rd;
  assign mem_write_strobe_n       = cmd_n_q.mem_wr;
  assign early_mem_write_strobe_n = cmd_n_q.mem_wr_early;

  assign stat.cycles   = cycles_q;
  assign stat.grant_ok = grant_ok;
  assign stat.strap    = strap_s;
  assign stat.state    = st_q;
  assign stat.status   = stat_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_ale_one_pulse:
    assert property (@(posedge pclk) disable iff (!presetn)
      addr_latch_strobe |=> !addr_latch_strobe)
    else $error("address strobe longer than one cycle");

  a_ale_on_start:
    assert property (@(posedge pclk) disable iff (!presetn)
      start |=> addr_latch_strobe && st_q == csb_pkg::CSB_ADDR)
    else $error("address strobe missing at cycle start");

  a_qual_blocks:
    assert property (@(posedge pclk) disable iff (!presetn)
      !qual_s |=> cmd_n_q == '1 && !data_xcvr_enable)
    else $error("command or enable active with qualifier low");

  a_grant_tristate:
    assert property (@(posedge pclk) disable iff (!presetn)
      grant_ns && !strap_s |=> !io_cmd_oe && !mem_cmd_oe)
    else $error("drivers enabled without bus grant");

  a_sys_wait_grant:
    assert property (@(posedge pclk) disable iff (!presetn)
      !strap_s && $fell(grant_ns) |-> ##1 (cmd_n_q == '1) [*2])
    else $error("command issued before grant delay");

  a_mem_needs_grant:
    assert property (@(posedge pclk) disable iff (!presetn)
      grant_ns |=> mem_read_strobe_n && early_mem_write_strobe_n)
    else $error("memory command without grant");

  a_iob_io_nowait:
    assert property (@(posedge pclk) disable iff (!presetn)
      strap_s && qual && is_iord && ph_rd |=> !io_read_strobe_n)
    else $error("I/O read delayed in I/O bus mode");

  a_passive_ends:
    assert property (@(posedge pclk) disable iff (!presetn)
      passive |=> cmd_n_q == '1 && !data_xcvr_enable && !xfer_direction)
    else $error("strobes remain after passive status");

  a_early_write_first:
    assert property (@(posedge pclk) disable iff (!presetn)
      $fell(early_mem_write_strobe_n) |-> mem_write_strobe_n)
    else $error("normal write not after early write");

  a_dir_on_write:
    assert property (@(posedge pclk) disable iff (!presetn)
      !mem_write_strobe_n |-> xfer_direction)
    else $error("direction low during memory write");

  a_cascade_irq_ack_strobe:
    assert property (@(posedge pclk) disable iff (!presetn)
      !strap_s && cascade_or_periph_enable |-> addr_latch_strobe
      && stat_q == `CSB_ST_IRQ_ACK_STROBE)
    else $error("cascade enable outside acknowledge start");

  a_one_command:
    assert property (@(posedge pclk) disable iff (!presetn)
      $onehot0(~{irq_ack_strobe_n, io_read_strobe_n, early_io_write_strobe_n,
                 mem_read_strobe_n, early_mem_write_strobe_n}))
    else $error("more than one command decoded");

  a_halt_quiet:
    assert property (@(posedge pclk) disable iff (!presetn)
      stat_q == `CSB_ST_HALT && st_q != csb_pkg::CSB_IDLE |=> cmd_n_q == '1)
    else $error("command issued in halt cycle");

  a_io_oe_strap:
    assert property (@(posedge pclk) disable iff (!presetn)
      strap_s |=> io_cmd_oe)
    else $error("I/O drivers off in I/O bus mode");

  a_sys_io_grant:
    assert property (@(posedge pclk) disable iff (!presetn)
      !strap_s && !grant_ok |=> io_read_strobe_n && io_write_strobe_n
      && early_io_write_strobe_n && irq_ack_strobe_n)
    else $error("I/O command before grant delay");

  a_irq_ack_strobe_read_phase:
    assert property (@(posedge pclk) disable iff (!presetn)
      is_irq_ack_strobe && qual && io_en && !passive && st_q == csb_pkg::CSB_EARLY
      |=> !irq_ack_strobe_n)
    else $error("acknowledge not timed like a read");

  a_dir_io_write:
    assert property (@(posedge pclk) disable iff (!presetn)
      !io_write_strobe_n |-> xfer_direction)
    else $error("direction low during I/O write");

  a_dir_read_low:
    assert property (@(posedge pclk) disable iff (!presetn)
      !mem_read_strobe_n || !io_read_strobe_n || !irq_ack_strobe_n |-> !xfer_direction)
    else $error("direction high during a read");

  a_peripheral_data_enable_n_excl:
    assert property (@(posedge pclk) disable iff (!presetn)
      strap_s && $past(strap_s) && !cascade_or_periph_enable |-> !data_xcvr_enable)
    else $error("both transceiver enables active in I/O bus mode");
endmodule

// >>> verification/csb_cpu_model.sv
// Model of the processor status pins, the bus arbiter and the command qualifier.
module csb_cpu_model (
  // Clock
  input  wire logic pclk,
  // Processor status, passive when all high
  output logic      status_line_0,
  output logic      status_line_1,
  output logic      status_line_2,
  // Arbitration and qualifier
  output logic      bus_grant_n,
  output logic      command_qualifier
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    {status_line_2, status_line_1, status_line_0} = 3'h7;
    bus_grant_n = 1'b1;
    command_qualifier = 1'b1;
  end

  // A long hold stands for a slow processor with wait states.
  task automatic cycle(input logic [2:0] code, input int len);
    @(posedge pclk);
    {status_line_2, status_line_1, status_line_0} <= code;
    repeat (len) @(posedge pclk);
    {status_line_2, status_line_1, status_line_0} <= 3'h7;
    repeat (4) @(posedge pclk);
  endtask

  // The grant can also move inside a machine cycle; the last test drops it during a memory read.
  task automatic grant(input logic v);
    @(posedge pclk);
    bus_grant_n <= v;
    repeat (6) @(posedge pclk);
  endtask

  // The qualifier settles while status is passive, well before the second clock state.
  task automatic qualify(input logic v);
    @(posedge pclk);
    command_qualifier <= v;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// >>> verification/csb_bus_controller_test.sv
// Self-checking bench for the status bus command controller.
module csb_bus_controller_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r1, r2;
  logic pready, pslverr, bus_mode_strap = 1'b0, err;
  logic s0, s1, s2, bus_grant_n, command_qualifier;
  logic irq_n, iord_n, iowr_n, eiowr_n, mrd_n, mwr_n, emwr_n;
  logic io_cmd_oe, mem_cmd_oe, addr_latch_strobe, data_xcvr_enable, xfer_direction;
  logic cascade_or_periph_enable, den_seen, dir_hi;
  csb_pkg::csb_cmd_t cmd_now, cmd_seen;
  int n_fail = 0, checks = 0, k = 0, first_wr, first_ew, ale_n, casc_n, peripheral_data_enable_n_lo;

  always #50 pclk = ~pclk;

  csb_bus_controller csb_bus_controller_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .status_line_0(s0), .status_line_1(s1), .status_line_2(s2),
    .bus_grant_n(bus_grant_n), .command_qualifier(command_qualifier),
    .bus_mode_strap(bus_mode_strap), .irq_ack_strobe_n(irq_n), .io_read_strobe_n(iord_n),
    .io_write_strobe_n(iowr_n), .early_io_write_strobe_n(eiowr_n),
    .mem_read_strobe_n(mrd_n), .mem_write_strobe_n(mwr_n),
    .early_mem_write_strobe_n(emwr_n), .io_cmd_oe(io_cmd_oe), .mem_cmd_oe(mem_cmd_oe),
    .addr_latch_strobe(addr_latch_strobe), .data_xcvr_enable(data_xcvr_enable),
    .xfer_direction(xfer_direction), .cascade_or_periph_enable(cascade_or_periph_enable));

  csb_cpu_model csb_cpu_model_i (
    .pclk(pclk), .status_line_0(s0), .status_line_1(s1), .status_line_2(s2),
    .bus_grant_n(bus_grant_n), .command_qualifier(command_qualifier));

  task automatic summarize();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Command set per status code, packed in the order of the command struct.
  function automatic csb_pkg::csb_cmd_t dec(input logic [2:0] c);
    case (c)
      3'h0: return 7'h40;
      3'h1: return 7'h20;
      3'h2: return 7'h18;
      3'h4, 3'h5: return 7'h04;
      3'h6: return 7'h03;
      default: return 7'h00;
    endcase
  endfunction

  // Outputs are sampled mid-cycle, clear of the edge that updates them.
  always @(negedge pclk)
  begin
    cmd_now = ~{irq_n, iord_n, iowr_n, eiowr_n, mrd_n, mwr_n, emwr_n};
    k = k + 1;
    cmd_seen = cmd_seen | cmd_now;
    if ((cmd_now.io_wr | cmd_now.mem_wr) && first_wr < 0)
      first_wr = k;
    if ((cmd_now.io_wr_early | cmd_now.mem_wr_early) && first_ew < 0)
      first_ew = k;
    ale_n += (addr_latch_strobe === 1'b1) ? 1 : 0;
    casc_n += (!bus_mode_strap && cascade_or_periph_enable === 1'b1) ? 1 : 0;
    peripheral_data_enable_n_lo += (bus_mode_strap && cascade_or_periph_enable === 1'b0) ? 1 : 0;
    den_seen = den_seen | data_xcvr_enable;
    dir_hi = dir_hi | xfer_direction;
  end

  // Runs one machine cycle; en low means every command must stay withheld.
  task automatic run(input logic [2:0] code, input int len, input logic en);
    csb_pkg::csb_cmd_t e;
    logic wr, io;
    e = en ? dec(code) : 7'h00;
    wr = e.io_wr | e.mem_wr;
    io = e.io_rd | e.io_wr;
    cmd_seen = 7'h00;
    {den_seen, dir_hi} = 2'h0;
    {first_wr, first_ew, ale_n, casc_n, peripheral_data_enable_n_lo} = {-32'sd1, -32'sd1, 96'h0};
    csb_cpu_model_i.cycle(code, len);
    check(cmd_seen === e, "command set");
    check(ale_n == ((code != 3'h7) ? 1 : 0), "one address strobe per cycle");
    check(casc_n == ((!bus_mode_strap && e.irq_ack_strobe) ? 1 : 0), "cascade pulse");
    if (wr)
      check(first_ew > 0 && first_ew == first_wr - 1, "early write leads");
    if (en)
      check(dir_hi === wr, "direction");
    if (!e.irq_ack_strobe)
      check(den_seen === (e.mem_rd | e.mem_wr | (!bus_mode_strap & io)), "den");
    if (bus_mode_strap && !e.irq_ack_strobe)
      check((peripheral_data_enable_n_lo > 0) === io, "peripheral enable");
    check({irq_n, iord_n, iowr_n, eiowr_n, mrd_n, mwr_n, emwr_n, data_xcvr_enable} === 8'hfe,
          "idle after passive");
  endtask

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0, r1);
    check(r1 === 32'h0 && err === 1'b0, "control reset value");
    apb(1'b0, 12'h00c, 32'h0, r1);
    check(err === 1'b1 && r1 === 32'h0, "unmapped address refused");
    csb_cpu_model_i.grant(1'b0);
    check(io_cmd_oe === 1'b1 && mem_cmd_oe === 1'b1, "drivers on with grant");
    apb(1'b0, 12'h008, 32'h0, r1);
    for (int c = 0; c < 8; c++)
      run(c[2:0], 4, 1'b1);
    run(3'h0, 3, 1'b1);
    run(3'h6, 9, 1'b1);
    apb(1'b0, 12'h008, 32'h0, r2);
    check(r2[15:0] - r1[15:0] === 16'h0009, "cycle count");
    csb_cpu_model_i.qualify(1'b0);
    run(3'h5, 4, 1'b0);
    run(3'h6, 4, 1'b0);
    csb_cpu_model_i.qualify(1'b1);
    apb(1'b1, 12'h000, 32'h1, r1);
    apb(1'b0, 12'h000, 32'h0, r1);
    check(r1 === 32'h1, "control readback");
    run(3'h1, 4, 1'b0);
    apb(1'b1, 12'h000, 32'h0, r1);
    csb_cpu_model_i.grant(1'b1);
    check(io_cmd_oe === 1'b0 && mem_cmd_oe === 1'b0, "drivers off without grant");
    run(3'h5, 4, 1'b0);
    run(3'h1, 4, 1'b0);
    bus_mode_strap <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0, r1);
    check(r1[5] === 1'b1, "strap in status");
    check(io_cmd_oe === 1'b1 && mem_cmd_oe === 1'b0, "I/O drivers free of grant");
    run(3'h1, 3, 1'b1);
    run(3'h2, 4, 1'b1);
    run(3'h0, 3, 1'b1);
    run(3'h5, 3, 1'b0);
    csb_cpu_model_i.grant(1'b0);
    run(3'h5, 3, 1'b1);
    run(3'h6, 4, 1'b1);
    // The grant is taken away while a memory read is under way.
    fork
      run(3'h5, 9, 1'b1);
      begin
        repeat (6) @(posedge pclk);
        csb_cpu_model_i.grant(1'b1);
      end
    join
    check(mem_cmd_oe === 1'b0 && io_cmd_oe === 1'b1, "memory drivers off after grant loss");
    summarize();
  end

  initial
  begin
    #2000000;
    n_fail++;
    summarize();
  end
endmodule
